// >>> pabm_mux.sv
// Alternate-function pin multiplexer for ports A to D with its register file.
//
// Summary of operation
// - Larger packages take the external clock on port B bit 3 set to clock input.
// - Smallest package takes the external clock from port A bit 1 instead.
// - Port A has no set-select bits; its enable bit alone connects the function.
// - Port A bits 0 and 6 are timer input or inverted output by timer mode.
// - Port A bits 0,1,6,7 carry timer 0 and timer 1 pins when enabled, bit 1 on the larger packages only.
// - Port A bit 2 is UART driver enable, bit 3 clear-to-send input.
// - Port A bit 4 is UART receive, bit 5 UART transmit when enabled.
// - Port B chooses by the low set-select bit only; the high one is ignored.
// - Port B bits 0-2 with select 1 give ADC and amplifier inputs, bit 4 an ADC input only.
// - Port B bit 3 is clock input with select 0 on the larger packages, ADC input 3 with select 1.
// - Voltage reference goes to port B bit 5 on 28 pins, port C bit 2 on 20.
// - Port C chooses by the low set-select bit only; the high one is ignored.
// - Port D has one function, connected once its enable bit is set.
// - In alternate mode the function, not the direction register, drives the pin.
//
// The register addresses and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module pabm_mux import pabm_pkg::*; (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  output logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  input wire logic [7:0] pin_a_i,
  input wire logic [7:0] pin_b_i,
  input wire logic [7:0] pin_c_i,
  input wire logic port_d_bit0_i,
  output pabm_pad_t pad_a_o,
  output pabm_pad_t pad_b_o,
  output pabm_pad_t pad_c_o,
  output logic port_d_bit0_o,
  output logic port_d_bit0_oe_o,
  input wire pabm_gpio_t gpio_a_i,
  input wire pabm_gpio_t gpio_b_i,
  input wire pabm_gpio_t gpio_c_i,
  input wire logic gpio_d_dout_i,
  input wire logic gpio_d_dir_i,
  input wire logic timer0_in_mode_i,
  input wire logic timer1_in_mode_i,
  input wire pabm_periph_out_t periph_i,
  output pabm_periph_in_t periph_o,
  output pabm_analog_t analog_o,
  output logic ext_reset_req_o
);
  pabm_wr_t wr;
  logic wr_en;
  logic wr_err;
  logic [31:0] rd_data;
  logic rd_err;
  logic [PIN_W-1:0] pin_s;
  logic [7:0] pa_s;
  logic [7:0] pb_s;
  logic [7:0] pc_s;
  logic pd_s;
  logic [7:0] pa_af_reg;
  logic [7:0] pb_af_reg;
  logic [7:0] pb_sel_lo_reg;
  logic [7:0] pb_sel_hi_reg;
  logic [7:0] pc_af_reg;
  logic [7:0] pc_sel_lo_reg;
  logic [7:0] pc_sel_hi_reg;
  logic pd_af_reg;
  pabm_variant_t variant_reg;
  pabm_pad_t pad_a_reg;
  pabm_pad_t pad_a_next;
  pabm_pad_t pad_b_reg;
  pabm_pad_t pad_b_next;
  pabm_pad_t pad_c_reg;
  pabm_pad_t pad_c_next;
  logic pd_out_reg;
  logic pd_out_next;
  logic pd_oe_reg;
  logic pd_oe_next;
  pabm_periph_in_t periph_reg;
  pabm_periph_in_t periph_next;
  pabm_analog_t analog_reg;
  pabm_analog_t analog_next;
  logic ext_clk_route_reg;
  logic ext_clk_route_next;
  logic reset_req_reg;
  logic reset_req_next;

  function automatic logic reg_mapped(input logic [ADDR_W-1:0] a);
    logic hit;
    hit = 1'b0;
    if (a[1:0] == 2'h0 && a <= OFS_ROUTE) begin
      hit = 1'b1;
    end
    return hit;
  endfunction

  function automatic logic lane0_hit(input pabm_wr_t w, input logic en,
                                     input logic [ADDR_W-1:0] ofs);
    return en && w.strb[0] && w.addr == ofs;
  endfunction

  pabm_axil u_axil (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .s_axi_awvalid_i(s_axi_awvalid_i),
    .s_axi_awready_o(s_axi_awready_o),
    .s_axi_awaddr_i(s_axi_awaddr_i),
    .s_axi_wvalid_i(s_axi_wvalid_i),
    .s_axi_wready_o(s_axi_wready_o),
    .s_axi_wdata_i(s_axi_wdata_i),
    .s_axi_wstrb_i(s_axi_wstrb_i),
    .s_axi_bvalid_o(s_axi_bvalid_o),
    .s_axi_bready_i(s_axi_bready_i),
    .s_axi_bresp_o(s_axi_bresp_o),
    .s_axi_arvalid_i(s_axi_arvalid_i),
    .s_axi_arready_o(s_axi_arready_o),
    .s_axi_araddr_i(s_axi_araddr_i),
    .s_axi_rvalid_o(s_axi_rvalid_o),
    .s_axi_rready_i(s_axi_rready_i),
    .s_axi_rdata_o(s_axi_rdata_o),
    .s_axi_rresp_o(s_axi_rresp_o),
    .wr_o(wr),
    .wr_en_o(wr_en),
    .wr_err_i(wr_err),
    .rd_data_i(rd_data),
    .rd_err_i(rd_err)
  );

  pabm_sync #(.W(PIN_W)) u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .d_i({~port_d_bit0_i, pin_c_i, pin_b_i, pin_a_i}),
    .q_o(pin_s)
  );

  assign pa_s = pin_s[7:0];
  assign pb_s = pin_s[15:8];
  assign pc_s = pin_s[23:16];
  // The reset pin is synchronised inverted, so a cleared stage reads it released.
  assign pd_s = ~pin_s[24];
  assign wr_err = ~reg_mapped(wr.addr);
  assign rd_err = ~reg_mapped(s_axi_araddr_i);

  // Enable registers; PD0 comes out of reset in its alternate (reset pin) role.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pa_af_reg <= RST_AF;
      pb_af_reg <= RST_AF;
      pc_af_reg <= RST_AF;
      pd_af_reg <= RST_PD_AF;
    end else begin
      if (lane0_hit(wr, wr_en, OFS_PA_AF)) begin
        pa_af_reg <= wr.data[7:0];
      end
      if (lane0_hit(wr, wr_en, OFS_PB_AF)) begin
        pb_af_reg <= wr.data[7:0];
      end
      if (lane0_hit(wr, wr_en, OFS_PC_AF)) begin
        pc_af_reg <= wr.data[7:0];
      end
      if (lane0_hit(wr, wr_en, OFS_PD_AF)) begin
        pd_af_reg <= wr.data[0];
      end
    end
  end

  // High select registers are stored for readback only and steer nothing.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pb_sel_lo_reg <= RST_SEL;
      pb_sel_hi_reg <= RST_SEL;
      pc_sel_lo_reg <= RST_SEL;
      pc_sel_hi_reg <= RST_SEL;
    end else begin
      if (lane0_hit(wr, wr_en, OFS_PB_SEL_LO)) begin
        pb_sel_lo_reg <= wr.data[7:0];
      end
      if (lane0_hit(wr, wr_en, OFS_PB_SEL_HI)) begin
        pb_sel_hi_reg <= wr.data[7:0];
      end
      if (lane0_hit(wr, wr_en, OFS_PC_SEL_LO)) begin
        pc_sel_lo_reg <= wr.data[7:0];
      end
      if (lane0_hit(wr, wr_en, OFS_PC_SEL_HI)) begin
        pc_sel_hi_reg <= wr.data[7:0];
      end
    end
  end

  // The illegal package code is refused and the old value kept.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      variant_reg <= RST_VARIANT;
    end else if (lane0_hit(wr, wr_en, OFS_VARIANT) && wr.data[1:0] != 2'h3) begin
      variant_reg <= pabm_variant_t'(wr.data[1:0]);
    end
  end

  always_comb begin
    rd_data = '0;
    unique case (s_axi_araddr_i)
      OFS_PA_AF: rd_data[7:0] = pa_af_reg;
      OFS_PB_AF: rd_data[7:0] = pb_af_reg;
      OFS_PB_SEL_LO: rd_data[7:0] = pb_sel_lo_reg;
      OFS_PB_SEL_HI: rd_data[7:0] = pb_sel_hi_reg;
      OFS_PC_AF: rd_data[7:0] = pc_af_reg;
      OFS_PC_SEL_LO: rd_data[7:0] = pc_sel_lo_reg;
      OFS_PC_SEL_HI: rd_data[7:0] = pc_sel_hi_reg;
      OFS_PD_AF: rd_data[0] = pd_af_reg;
      OFS_VARIANT: rd_data[1:0] = variant_reg;
      OFS_PIN_AB: rd_data[15:0] = {pb_s, pa_s};
      OFS_PIN_CD: rd_data[8:0] = {pd_s, pc_s};
      OFS_ROUTE: rd_data[13:0] = {ext_clk_route_reg, analog_reg};
      default: rd_data = '0;
    endcase
  end

  // Pin routing; a pin left out of alternate mode follows its port registers.
  always_comb begin
    pad_a_next.out = gpio_a_i.dout;
    pad_a_next.oe = gpio_a_i.dir;
    pad_b_next.out = gpio_b_i.dout;
    pad_b_next.oe = gpio_b_i.dir;
    pad_c_next.out = gpio_c_i.dout;
    pad_c_next.oe = gpio_c_i.dir;
    pd_out_next = gpio_d_dout_i;
    pd_oe_next = gpio_d_dir_i;
    periph_next.timer0_input = 1'b0;
    periph_next.timer1_input = 1'b0;
    periph_next.uart0_clear_to_send = SERIAL_IDLE;
    periph_next.uart0_receive_line = SERIAL_IDLE;
    periph_next.ext_clock_in = 1'b0;
    analog_next = '0;
    ext_clk_route_next = 1'b0;
    reset_req_next = 1'b0;
    // Port A: the enable bit alone connects the function; for bit 1 the package picks which one.
    if (pa_af_reg[0]) begin
      if (timer0_in_mode_i) begin
        pad_a_next.oe[0] = 1'b0;
        periph_next.timer0_input = pa_s[0];
      end else begin
        pad_a_next.out[0] = ~periph_i.timer0_output;
        pad_a_next.oe[0] = 1'b1;
      end
    end
    if (pa_af_reg[1]) begin
      if (variant_reg == PKG_8PIN) begin
        pad_a_next.oe[1] = 1'b0;
        periph_next.ext_clock_in = pa_s[1];
        ext_clk_route_next = 1'b1;
      end else begin
        pad_a_next.out[1] = periph_i.timer0_output;
        pad_a_next.oe[1] = 1'b1;
      end
    end
    if (pa_af_reg[2]) begin
      pad_a_next.out[2] = periph_i.uart0_driver_enable;
      pad_a_next.oe[2] = 1'b1;
    end
    if (pa_af_reg[3]) begin
      pad_a_next.oe[3] = 1'b0;
      periph_next.uart0_clear_to_send = pa_s[3];
    end
    if (pa_af_reg[4]) begin
      pad_a_next.oe[4] = 1'b0;
      periph_next.uart0_receive_line = pa_s[4];
    end
    if (pa_af_reg[5]) begin
      pad_a_next.out[5] = periph_i.uart0_transmit_line;
      pad_a_next.oe[5] = 1'b1;
    end
    if (pa_af_reg[6]) begin
      if (timer1_in_mode_i) begin
        pad_a_next.oe[6] = 1'b0;
        periph_next.timer1_input = pa_s[6];
      end else begin
        pad_a_next.out[6] = ~periph_i.timer1_output;
        pad_a_next.oe[6] = 1'b1;
      end
    end
    if (pa_af_reg[7]) begin
      pad_a_next.out[7] = periph_i.timer1_output;
      pad_a_next.oe[7] = 1'b1;
    end
    // Port B: only the low select bit matters; reserved codes stay GPIO, except bit 3 on the 8-pin package, which is only made an input.
    for (int i = 0; i < 3; i++) begin
      if (pb_af_reg[i] && pb_sel_lo_reg[i]) begin
        pad_b_next.oe[i] = 1'b0;
        analog_next.adc_sel[i] = 1'b1;
        analog_next.low_power_amp[i] = 1'b1;
      end
    end
    if (pb_af_reg[3]) begin
      pad_b_next.oe[3] = 1'b0;
      if (pb_sel_lo_reg[3]) begin
        analog_next.adc_sel[3] = 1'b1;
      end else if (variant_reg != PKG_8PIN) begin
        periph_next.ext_clock_in = pb_s[3];
        ext_clk_route_next = 1'b1;
      end
    end
    if (pb_af_reg[4] && pb_sel_lo_reg[4]) begin
      pad_b_next.oe[4] = 1'b0;
      analog_next.adc_sel[7] = 1'b1;
    end
    if (pb_af_reg[5] && pb_sel_lo_reg[5] && variant_reg == PKG_28PIN) begin
      pad_b_next.oe[5] = 1'b0;
      analog_next.vref_pb5 = 1'b1;
    end
    // Bits 6 and 7 of port B are never taken over.
    // Port C: low select bit picks analog inputs or comparator output.
    for (int i = 0; i < 3; i++) begin
      if (pc_af_reg[i] && pc_sel_lo_reg[i]) begin
        pad_c_next.oe[i] = 1'b0;
        analog_next.adc_sel[4+i] = 1'b1;
      end
    end
    if (pc_af_reg[2] && pc_sel_lo_reg[2] && variant_reg == PKG_20PIN) begin
      analog_next.vref_pc2 = 1'b1;
    end
    if (pc_af_reg[3] && !pc_sel_lo_reg[3]) begin
      pad_c_next.out[3] = periph_i.comparator_out;
      pad_c_next.oe[3] = 1'b1;
    end
    // Port D: the single reset-pin role follows its enable bit directly.
    if (pd_af_reg) begin
      pd_out_next = 1'b0;
      pd_oe_next = 1'b0;
      reset_req_next = ~pd_s;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pad_a_reg <= '0;
      pad_b_reg <= '0;
      pad_c_reg <= '0;
      pd_out_reg <= 1'b0;
      pd_oe_reg <= 1'b0;
    end else begin
      pad_a_reg <= pad_a_next;
      pad_b_reg <= pad_b_next;
      pad_c_reg <= pad_c_next;
      pd_out_reg <= pd_out_next;
      pd_oe_reg <= pd_oe_next;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      periph_reg <= '0;
      analog_reg <= '0;
      ext_clk_route_reg <= 1'b0;
      reset_req_reg <= 1'b0;
    end else begin
      periph_reg <= periph_next;
      analog_reg <= analog_next;
      ext_clk_route_reg <= ext_clk_route_next;
      reset_req_reg <= reset_req_next;
    end
  end

  assign pad_a_o = pad_a_reg;
  assign pad_b_o = pad_b_reg;
  assign pad_c_o = pad_c_reg;
  assign port_d_bit0_o = pd_out_reg;
  assign port_d_bit0_oe_o = pd_oe_reg;
  assign periph_o = periph_reg;
  assign analog_o = analog_reg;
  assign ext_reset_req_o = reset_req_reg;
endmodule

// >>> pabm_pkg.sv
// Package of offsets, reset values and carrier types for the port alternate-function mux.
package pabm_pkg;
  localparam int ADDR_W = 8;
  localparam int PIN_W = 25;
  localparam logic [7:0] OFS_PA_AF = 8'h00;
  localparam logic [7:0] OFS_PB_AF = 8'h04;
  localparam logic [7:0] OFS_PB_SEL_LO = 8'h08;
  localparam logic [7:0] OFS_PB_SEL_HI = 8'h0c;
  localparam logic [7:0] OFS_PC_AF = 8'h10;
  localparam logic [7:0] OFS_PC_SEL_LO = 8'h14;
  localparam logic [7:0] OFS_PC_SEL_HI = 8'h18;
  localparam logic [7:0] OFS_PD_AF = 8'h1c;
  localparam logic [7:0] OFS_VARIANT = 8'h20;
  localparam logic [7:0] OFS_PIN_AB = 8'h24;
  localparam logic [7:0] OFS_PIN_CD = 8'h28;
  localparam logic [7:0] OFS_ROUTE = 8'h2c;
  localparam logic [7:0] RST_AF = 8'h00;
  localparam logic [7:0] RST_SEL = 8'h00;
  localparam logic RST_PD_AF = 1'b1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic SERIAL_IDLE = 1'b1;
  typedef enum logic [1:0] {
    PKG_8PIN = 2'h0,
    PKG_20PIN = 2'h1,
    PKG_28PIN = 2'h2
  } pabm_variant_t;
  localparam pabm_variant_t RST_VARIANT = PKG_28PIN;
  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] dir;
  } pabm_gpio_t;
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pabm_pad_t;
  typedef struct packed {
    logic timer0_input;
    logic timer1_input;
    logic uart0_clear_to_send;
    logic uart0_receive_line;
    logic ext_clock_in;
  } pabm_periph_in_t;
  typedef struct packed {
    logic timer0_output;
    logic timer1_output;
    logic uart0_driver_enable;
    logic uart0_transmit_line;
    logic comparator_out;
  } pabm_periph_out_t;
  typedef struct packed {
    logic [7:0] adc_sel;
    logic [2:0] low_power_amp;
    logic vref_pb5;
    logic vref_pc2;
  } pabm_analog_t;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } pabm_wr_t;
endpackage

// >>> pabm_sync.sv
// Two-stage synchroniser for asynchronous pin levels.
`timescale 1ns/1ps
module pabm_sync import pabm_pkg::*; #(
  parameter int W = PIN_W
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      q_reg <= '0;
    end else begin
      meta_reg <= d_i;
      q_reg <= meta_reg;
    end
  end

  assign q_o = q_reg;
endmodule

// >>> pabm_axil.sv
// AXI4-Lite slave front end that turns bus transfers into register strobes.
`timescale 1ns/1ps
module pabm_axil import pabm_pkg::*; (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  output logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output pabm_wr_t wr_o,
  output logic wr_en_o,
  input wire logic wr_err_i,
  input wire logic [31:0] rd_data_i,
  input wire logic rd_err_i
);
  logic awready_reg;
  logic wready_reg;
  logic aw_have_reg;
  logic w_have_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  pabm_wr_t wr_reg;

  // Address and data may arrive in either order; the write fires once both are held.
  assign wr_en_o = aw_have_reg & w_have_reg & ~bvalid_reg;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      awready_reg <= 1'b1;
      aw_have_reg <= 1'b0;
      wr_reg.addr <= '0;
    end else if (s_axi_awvalid_i && awready_reg) begin
      awready_reg <= 1'b0;
      aw_have_reg <= 1'b1;
      wr_reg.addr <= s_axi_awaddr_i;
    end else if (wr_en_o) begin
      aw_have_reg <= 1'b0;
    end else if (bvalid_reg && s_axi_bready_i) begin
      awready_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      wready_reg <= 1'b1;
      w_have_reg <= 1'b0;
      wr_reg.data <= '0;
      wr_reg.strb <= '0;
    end else if (s_axi_wvalid_i && wready_reg) begin
      wready_reg <= 1'b0;
      w_have_reg <= 1'b1;
      wr_reg.data <= s_axi_wdata_i;
      wr_reg.strb <= s_axi_wstrb_i;
    end else if (wr_en_o) begin
      w_have_reg <= 1'b0;
    end else if (bvalid_reg && s_axi_bready_i) begin
      wready_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else if (wr_en_o) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_err_i ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready_i) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Read data is captured in the cycle the address is taken.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
    end else if (s_axi_arvalid_i && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_data_i;
      rresp_reg <= rd_err_i ? RESP_SLVERR : RESP_OKAY;
    end else if (rvalid_reg && s_axi_rready_i) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_awready_o = awready_reg;
  assign s_axi_wready_o = wready_reg;
  assign s_axi_bvalid_o = bvalid_reg;
  assign s_axi_bresp_o = bresp_reg;
  assign s_axi_arready_o = arready_reg;
  assign s_axi_rvalid_o = rvalid_reg;
  assign s_axi_rdata_o = rdata_reg;
  assign s_axi_rresp_o = rresp_reg;
  assign wr_o = wr_reg;
endmodule

// >>> pabm_periph_model.sv
// Stand-in for the timers, UART and comparator that feed the pin mux.
`timescale 1ns/1ps
module pabm_periph_model import pabm_pkg::*; (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  output pabm_periph_out_t periph_o
);
  logic [4:0] cnt_reg;
  // An odd step walks every output pattern, so stale routing shows up.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cnt_reg <= 5'h00;
    end else begin
      cnt_reg <= cnt_reg + 5'h07;
    end
  end
  assign periph_o = pabm_periph_out_t'(cnt_reg);
endmodule

// >>> pabm_mux_chk.sv
// Checker of pin routing and bus answers of the pin mux.
`timescale 1ns/1ps
module pabm_mux_chk import pabm_pkg::*; (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [7:0] pin_a_i,
  input wire logic [7:0] pin_b_i,
  input wire pabm_gpio_t gpio_a_i,
  input wire pabm_gpio_t gpio_b_i,
  input wire logic timer0_in_mode_i,
  input wire logic timer1_in_mode_i,
  input wire pabm_periph_out_t periph_i,
  input wire pabm_periph_in_t periph_o,
  input wire pabm_pad_t pad_a_o,
  input wire pabm_pad_t pad_b_o,
  input wire pabm_analog_t analog_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  sequence s_live;
    !$past(rst_i);
  endsequence
  sequence s_settled;
    !$past(rst_i, 3) && !$past(rst_i, 2) && !$past(rst_i);
  endsequence
  // A pin driven while its direction bit said input is in alternate mode.
  sequence s_alt(o, d);
    s_live ##0 (o && !$past(d));
  endsequence
  sequence s_wr_both;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  a_pb_hi_gpio: assert property (s_live |-> pad_b_o.out[7:6] == $past(gpio_b_i.dout[7:6])
    && pad_b_o.oe[7:6] == $past(gpio_b_i.dir[7:6])) else $error("port B upper pins not GPIO");
  a_pb_analog_in: assert property (s_live |->
    (pad_b_o.oe[5:0] & ~$past(gpio_b_i.dir[5:0])) == 6'h00) else $error("port B pin driven");
  a_pa0_compl: assert property (s_alt(pad_a_o.oe[0], gpio_a_i.dir[0]) |->
    pad_a_o.out[0] == !$past(periph_i.timer0_output) && !$past(timer0_in_mode_i))
    else $error("pin A0 not timer 0 complement");
  a_pa6_compl: assert property (s_alt(pad_a_o.oe[6], gpio_a_i.dir[6]) |->
    pad_a_o.out[6] == !$past(periph_i.timer1_output) && !$past(timer1_in_mode_i))
    else $error("pin A6 not timer 1 complement");
  a_pa1_timer: assert property (s_alt(pad_a_o.oe[1], gpio_a_i.dir[1]) |->
    pad_a_o.out[1] == $past(periph_i.timer0_output)) else $error("pin A1 not timer 0");
  a_pa7_timer: assert property (s_alt(pad_a_o.oe[7], gpio_a_i.dir[7]) |->
    pad_a_o.out[7] == $past(periph_i.timer1_output)) else $error("pin A7 not timer 1");
  a_pa2_de: assert property (s_alt(pad_a_o.oe[2], gpio_a_i.dir[2]) |->
    pad_a_o.out[2] == $past(periph_i.uart0_driver_enable)) else $error("pin A2 not DE");
  a_pa5_tx: assert property (s_alt(pad_a_o.oe[5], gpio_a_i.dir[5]) |->
    pad_a_o.out[5] == $past(periph_i.uart0_transmit_line)) else $error("pin A5 not TX");
  a_rx_route: assert property (s_settled ##0 !periph_o.uart0_receive_line |->
    !$past(pin_a_i[4], 3)) else $error("receive line low without pin");
  a_clk_route: assert property (s_settled ##0 periph_o.ext_clock_in |->
    $past(pin_a_i[1], 3) || $past(pin_b_i[3], 3)) else $error("clock input without pin");
  a_vref_once: assert property (!(analog_o.vref_pb5 && analog_o.vref_pc2))
    else $error("reference on two pins");
  a_rd_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
    s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("read answer dropped");
  a_wr_answer: assert property (s_wr_both |-> ##2 s_axi_bvalid_o)
    else $error("write answer late");
endmodule

// >>> test_port_ab_alt_function_mux.sv
// Self-checking bench of the port alternate-function mux.
`timescale 1ns/1ps
module test_port_ab_alt_function_mux import pabm_pkg::*;;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
  logic [7:0] aw_a = 8'h00, ar_a = 8'h00, pin_a = 8'h00, pin_b = 8'h00, pin_c = 8'h00;
  logic [31:0] w_d = 32'h0, r_d, seed = 32'hafe3;
  logic aw_rdy, w_rdy, b_v, ar_rdy, r_v, pd_o, pd_oe, rst_req, pin_d = 1'b0;
  logic [1:0] b_resp, r_resp, prev_d;
  logic gd_o = 1'b0, gd_d = 1'b0, t0m = 1'b1, t1m = 1'b1;
  pabm_gpio_t ga = '0, gb = '0, gc = '0;
  pabm_pad_t pad_a, pad_b, pad_c;
  pabm_periph_out_t per_i;
  pabm_periph_in_t per_o;
  pabm_analog_t ana;
  int bad_count = 0, checked = 0, cyc = 0;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [7:0] ta[9] = '{OFS_PB_SEL_LO, OFS_PB_AF, OFS_PB_SEL_HI, OFS_VARIANT, OFS_PC_SEL_LO,
    OFS_PC_SEL_HI, OFS_PC_AF, OFS_PB_AF, OFS_VARIANT};
  logic [7:0] td[9] = '{8'hff, 8'hff, 8'hff, 8'h01, 8'hff, 8'hff, 8'h07, 8'h00, 8'h02};
  logic [12:0] te[9] = '{13'h0, 13'h11fe, 13'h11fe, 13'h11fc, 13'h11fc, 13'h11fc,
    13'h1ffd, 13'h0e01, 13'h0e00};
  pabm_mux i_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .s_axi_awvalid_i(aw_v),
    .s_axi_awready_o(aw_rdy), .s_axi_awaddr_i(aw_a), .s_axi_wvalid_i(w_v),
    .s_axi_wready_o(w_rdy), .s_axi_wdata_i(w_d), .s_axi_wstrb_i(4'hf),
    .s_axi_bvalid_o(b_v), .s_axi_bready_i(b_r), .s_axi_bresp_o(b_resp),
    .s_axi_arvalid_i(ar_v), .s_axi_arready_o(ar_rdy), .s_axi_araddr_i(ar_a),
    .s_axi_rvalid_o(r_v), .s_axi_rready_i(r_r), .s_axi_rdata_o(r_d), .s_axi_rresp_o(r_resp),
    .pin_a_i(pin_a), .pin_b_i(pin_b), .pin_c_i(pin_c), .port_d_bit0_i(pin_d),
    .pad_a_o(pad_a), .pad_b_o(pad_b), .pad_c_o(pad_c), .port_d_bit0_o(pd_o),
    .port_d_bit0_oe_o(pd_oe), .gpio_a_i(ga), .gpio_b_i(gb), .gpio_c_i(gc),
    .gpio_d_dout_i(gd_o), .gpio_d_dir_i(gd_d), .timer0_in_mode_i(t0m),
    .timer1_in_mode_i(t1m), .periph_i(per_i), .periph_o(per_o), .analog_o(ana),
    .ext_reset_req_o(rst_req));
  pabm_periph_model i_per (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .periph_o(per_i));
  always #5 clk_sys_i = ~clk_sys_i;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic chk(input string n, input logic [33:0] e, input logic [33:0] g);
    checked++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      bad_count++;
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    logic ad;
    logic wd;
    ad = 1'b0;
    wd = 1'b0;
    bq.push_back(e);
    aw_a <= a;
    w_d <= d;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge clk_sys_i);
      if (!ad && aw_rdy) begin
        ad = 1'b1;
        aw_v <= 1'b0;
      end
      if (!wd && w_rdy) begin
        wd = 1'b1;
        w_v <= 1'b0;
      end
    end
    b_r <= 1'b1;
    do @(posedge clk_sys_i); while (!b_v);
    b_r <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    rq.push_back({e, d});
    ar_a <= a;
    ar_v <= 1'b1;
    do @(posedge clk_sys_i); while (!ar_rdy);
    ar_v <= 1'b0;
    r_r <= 1'b1;
    do @(posedge clk_sys_i); while (!r_v);
    r_r <= 1'b0;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  // Port logic changes every cycle so routing faults cannot hide behind constants.
  always @(posedge clk_sys_i) begin
    seed <= xs(seed);
    ga <= seed[15:0];
    gb <= seed[31:16];
    gc <= seed[23:8];
    {gd_o, gd_d} <= seed[1:0];
    prev_d <= {gd_o, gd_d};
    pin_c <= seed[7:0];
  end
  always @(posedge clk_sys_i) begin
    if (r_v && r_r) chk("read", rq.pop_front(), {r_resp, r_d});
    if (b_v && b_r) chk("bresp", bq.pop_front(), b_resp);
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      summarize();
    end
  end
  initial begin
    repeat (20) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    rd(OFS_PB_SEL_LO, 32'h0, RESP_OKAY);
    rd(OFS_PD_AF, 32'h1, RESP_OKAY);
    rd(OFS_VARIANT, 32'h2, RESP_OKAY);
    rd(8'h30, 32'h0, RESP_SLVERR);
    wr(8'h31, 32'hff, RESP_SLVERR);
    settle(2);
    chk("pd_oe", 1'b0, pd_oe);
    chk("rst_req", 1'b1, rst_req);
    wr(OFS_PD_AF, 32'h0, RESP_OKAY);
    settle(2);
    chk("pd_oe", prev_d[0], pd_oe);
    chk("pd_o", prev_d[1], pd_o);
    for (int k = 0; k < 2; k++) begin
      wr(OFS_PA_AF, k ? 32'hff : 32'h0, RESP_OKAY);
      pin_a <= k ? 8'h51 : 8'hae;
      settle(4);
      chk("periph", k ? 5'b11010 : 5'b00110, per_o);
    end
    t0m <= 1'b0;
    t1m <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      wr(ta[i], {24'h0, td[i]}, RESP_OKAY);
      settle(2);
      chk("analog", te[i], ana);
    end
    rd(OFS_PB_SEL_HI, 32'hff, RESP_OKAY);
    wr(OFS_PC_SEL_LO, 32'hf7, RESP_OKAY);
    wr(OFS_PC_AF, 32'h0f, RESP_OKAY);
    wr(OFS_PB_SEL_LO, 32'hf7, RESP_OKAY);
    wr(OFS_PB_AF, 32'h08, RESP_OKAY);
    pin_b <= 8'h08;
    settle(4);
    chk("clock", 1'b1, per_o.ext_clock_in);
    chk("pad_c", 1'b1, pad_c.oe[3]);
    rd(OFS_ROUTE, 32'h2e00, RESP_OKAY);
    pin_b <= 8'h00;
    settle(4);
    chk("clock", 1'b0, per_o.ext_clock_in);
    wr(OFS_VARIANT, 32'h0, RESP_OKAY);
    pin_a <= 8'h02;
    settle(4);
    chk("clock", 1'b1, per_o.ext_clock_in);
    pin_a <= 8'h00;
    pin_b <= 8'h08;
    settle(4);
    chk("clock", 1'b0, per_o.ext_clock_in);
    summarize();
  end
endmodule
bind pabm_mux pabm_mux_chk i_chk (.clk_sys_i, .rst_i, .s_axi_awvalid_i, .s_axi_awready_o,
  .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_rvalid_o, .s_axi_rready_i,
  .s_axi_rdata_o, .pin_a_i, .pin_b_i, .gpio_a_i, .gpio_b_i, .timer0_in_mode_i,
  .timer1_in_mode_i, .periph_i, .periph_o, .pad_a_o, .pad_b_o, .analog_o);
